// [common/cdr_pkg.sv]
// cdr_pkg: constants, layouts and types for the lock-mode controller
// assumes a single 20 MHz core clock and an Avalon-MM register bus
package cdr_pkg;
	// register byte addresses
	localparam logic [4:0] CTRL_ADDR = 5'h00;
	localparam logic [4:0] THR_ADDR = 5'h04;
	localparam logic [4:0] RATE_ADDR = 5'h08;
	localparam logic [4:0] STAT_ADDR = 5'h0c;
	localparam logic [4:0] WORD_ADDR = 5'h10;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] THR_RST = 8'h40;
	localparam logic [7:0] RATE_RST = 8'h14;
	// phase match window, milli-UI
	localparam logic [9:0] PHASE_TOL_MUI = 10'h050;
	// deserialization factor codes
	localparam logic [1:0] WID_8 = 2'h0;
	localparam logic [1:0] WID_10 = 2'h1;
	localparam logic [1:0] WID_16 = 2'h2;
	localparam logic [1:0] WID_20 = 2'h3;
	localparam int WORD_W = 20;
	// control register, bit 7 down to bit 0
	typedef struct packed {
		logic dig_rst;
		logic ana_rst;
		logic [1:0] width;
		logic force_data;
		logic force_ref;
		logic manual_en;
		logic force_det;
	} cdr_ctrl_t;
	// status register, bit 3 down to bit 0
	typedef struct packed {
		logic data_mode;
		logic ref_lock;
		logic freq_lock;
		logic sig_det;
	} cdr_stat_t;
	typedef enum logic [0:0] {
		ST_LOCK_TO_REFERENCE = 1'b0,
		ST_LOCK_TO_DATA = 1'b1
	} cdr_mode_t;
	// index of the last bit of a word for a factor code
	function automatic logic [4:0] cdr_last_bit(input logic [1:0] w);
		case (w)
			WID_8: cdr_last_bit = 5'h07;
			WID_10: cdr_last_bit = 5'h09;
			WID_16: cdr_last_bit = 5'h0f;
			default: cdr_last_bit = 5'h13;
		endcase
	endfunction : cdr_last_bit
endpackage : cdr_pkg

// [rtl/cdr_lock_ctrl.sv]
// cdr_lock_ctrl: signal detect, lock-mode controller and deserializer
// assumes analog sensors and the serial bit strobe are synchronous to core_clk_i
//
// Functional notes
// RULE1: signal present while level exceeds threshold
// RULE2: forced detection keeps signal present high
// RULE3: signal loss returns loop to reference
// RULE4: reference mode: frequency detector on, lock flag
// RULE5: data mode: detector idle, lock flag meaningless
// RULE6: dividers give recovered clock at half rate
// RULE7: partner holds PCS reset until frequency lock
// RULE8: data mode only after reference lock
// RULE9: decode force-reference and force-data inputs
// RULE10: without manual inputs, always automatic mode
// RULE11: automatic mode starts in reference mode
// RULE12: enter data mode on signal, ppm, phase
// RULE13: leave data mode on signal and ppm loss
// RULE14: force-reference drives frequency lock low
// RULE15: force-data drives frequency lock high
// RULE16: word widths of 8, 10, 16, 20
// RULE17: first serial bit is word LSB
// RULE18: bits captured fast, words presented slow
// RULE19: one independent recovery loop per channel
// RULE20: digital reset resets receiver PCS
// RULE21: analog reset resets PMA and deserializer
// RULE22: analog reset clears lock flags, reference mode
//
// Added by the designer: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module cdr_lock_ctrl (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// avalon-mm slave
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// analog sensors
	input wire logic [7:0] rx_level_i,
	input wire logic ppm_ok_i,
	input wire logic [9:0] phase_err_i,
	input wire logic ref_lock_i,
	// serial data, one strobe per high-speed bit
	input wire logic ser_bit_i,
	input wire logic ser_valid_i,
	// loop control and status
	output logic sig_det_o,
	output logic freq_lock_o,
	output logic ref_lock_o,
	output logic data_mode_o,
	output logic phase_freq_detector_en_o,
	output logic data_pd_en_o,
	output logic [6:0] fb_div_o,
	// parallel side
	output logic [cdr_pkg::WORD_W-1:0] word_o,
	output logic word_valid_o,
	output logic pcs_rst_o
);
	import cdr_pkg::*;

	cdr_ctrl_t ctrl;
	logic [7:0] thr;
	logic [7:0] rate;
	cdr_mode_t mode;
	cdr_mode_t next_mode;
	cdr_stat_t stat;
	logic auto_mode;
	logic phase_ok;
	logic enter_data;
	logic ana;
	logic [4:0] bit_cnt;
	logic [4:0] last_bit;
	logic [WORD_W-1:0] asm_word;
	logic [WORD_W-1:0] next_asm;
	logic wr_take;
	logic rd_take;

	assign ana = ctrl.ana_rst;
	assign wr_take = avs_write_i && !avs_waitrequest_o;
	assign rd_take = avs_read_i && avs_waitrequest_o;

	// bus handshake: every access answers one edge after it is seen
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			avs_waitrequest_o <= 1'b1;
		end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
			avs_waitrequest_o <= 1'b0;
		end else begin
			avs_waitrequest_o <= 1'b1;
		end
	end

	// register writes; only lane 0 carries data
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			ctrl <= CTRL_RST;
			thr <= THR_RST;
			rate <= RATE_RST;
		end else if (wr_take && avs_byteenable_i[0]) begin
			case (avs_address_i)
				CTRL_ADDR: ctrl <= avs_writedata_i[7:0];
				THR_ADDR: thr <= avs_writedata_i[7:0];
				RATE_ADDR: rate <= avs_writedata_i[7:0];
				default: ;
			endcase
		end
	end

	assign stat = '{data_mode: data_mode_o, ref_lock: ref_lock_o,
		freq_lock: freq_lock_o, sig_det: sig_det_o};

	// read data, unmapped reads return zero
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			avs_readdata_o <= 32'h0;
		end else if (rd_take) begin
			case (avs_address_i)
				CTRL_ADDR: avs_readdata_o <= {24'h0, ctrl};
				THR_ADDR: avs_readdata_o <= {24'h0, thr};
				RATE_ADDR: avs_readdata_o <= {24'h0, rate};
				STAT_ADDR: avs_readdata_o <= {28'h0, stat};
				WORD_ADDR: avs_readdata_o <= {12'h0, word_o};
				default: avs_readdata_o <= 32'h0;
			endcase
		end
	end

	// signal detect; force wins even over analog reset
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sig_det_o <= 1'b0;
		end else begin
			sig_det_o <= ctrl.force_det || (!ana && (rx_level_i > thr)); // RULE1 RULE2
		end
	end

	// half-rate loop: feedback divide is half the rate ratio
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			fb_div_o <= 7'h0;
		end else begin
			fb_div_o <= rate[7:1]; // RULE6
		end
	end

	// manual inputs count only when the manual option is on
	assign auto_mode = !ctrl.manual_en || (!ctrl.force_ref && !ctrl.force_data); // RULE9 RULE10
	assign phase_ok = phase_err_i <= PHASE_TOL_MUI;
	// reference lock must precede data mode
	assign enter_data = ref_lock_i && sig_det_o && ppm_ok_i && phase_ok; // RULE8 RULE12

	// one loop per channel; replicate the module per lane
	always_comb begin
		next_mode = mode; // RULE19
		if (!auto_mode) begin
			next_mode = ctrl.force_data ? ST_LOCK_TO_DATA : ST_LOCK_TO_REFERENCE; // RULE9
		end else begin
			case (mode)
				ST_LOCK_TO_REFERENCE: begin
					if (enter_data) begin
						next_mode = ST_LOCK_TO_DATA; // RULE11 RULE12
					end
				end
				ST_LOCK_TO_DATA: begin
					// signal loss alone is enough; it covers loss with ppm drift too
					if (!sig_det_o) begin
						next_mode = ST_LOCK_TO_REFERENCE; // RULE3 RULE13
					end
				end
				default: next_mode = ST_LOCK_TO_REFERENCE;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || ana) begin
			mode <= ST_LOCK_TO_REFERENCE; // RULE11 RULE22
		end else begin
			mode <= next_mode;
		end
	end

	// frequency lock, data mode and detector enables follow the mode being entered; ref_lock_o follows ref_lock_i
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || ana) begin
			freq_lock_o <= 1'b0; // RULE22
			ref_lock_o <= 1'b0;
			data_mode_o <= 1'b0;
			phase_freq_detector_en_o <= 1'b0;
			data_pd_en_o <= 1'b0;
		end else begin
			freq_lock_o <= next_mode == ST_LOCK_TO_DATA; // RULE14 RULE15
			// in data mode this flag is passed raw and carries no meaning
			ref_lock_o <= ref_lock_i; // RULE4 RULE5
			data_mode_o <= next_mode == ST_LOCK_TO_DATA;
			phase_freq_detector_en_o <= next_mode == ST_LOCK_TO_REFERENCE; // RULE4
			data_pd_en_o <= next_mode == ST_LOCK_TO_DATA; // RULE5
		end
	end

	// deserializer: bit i of the word takes the i-th serial bit
	assign last_bit = cdr_last_bit(ctrl.width); // RULE16
	for (genvar i = 0; i < WORD_W; i++) begin : g_bit
		assign next_asm[i] = (ser_valid_i && bit_cnt == 5'(i)) ? ser_bit_i : asm_word[i]; // RULE17
	end

	// assembly clears per word so unused high bits stay zero
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || ana) begin
			bit_cnt <= 5'h0; // RULE21
			asm_word <= '0;
		end else if (ser_valid_i && bit_cnt >= last_bit) begin
			bit_cnt <= 5'h0;
			asm_word <= '0;
		end else begin
			bit_cnt <= ser_valid_i ? bit_cnt + 5'h1 : bit_cnt;
			asm_word <= next_asm;
		end
	end

	// word strobe stands for the low-speed parallel clock
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || ana) begin
			word_o <= '0; // RULE21
			word_valid_o <= 1'b0;
		end else begin
			word_valid_o <= ser_valid_i && bit_cnt >= last_bit; // RULE18
			if (ser_valid_i && bit_cnt >= last_bit) begin
				word_o <= next_asm;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			pcs_rst_o <= 1'b1;
		end else begin
			pcs_rst_o <= ctrl.dig_rst; // RULE20
		end
	end

	sequence last_bit_s;
		ser_valid_i && bit_cnt >= last_bit && !ana;
	endsequence

	sequence word_out_s;
		word_valid_o ##1 !word_valid_o;
	endsequence

	sig_force_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE2
		ctrl.force_det |=> sig_det_o)
		else $error("forced detect not high");

	sig_level_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE1
		(!ctrl.force_det && !ana) |=> sig_det_o == $past(rx_level_i > thr))
		else $error("signal detect does not follow level");

	drop_ref_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE3
		(auto_mode && mode == ST_LOCK_TO_DATA && !sig_det_o) |=> mode == ST_LOCK_TO_REFERENCE && !freq_lock_o)
		else $error("signal loss did not return to reference");

	enter_data_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE12
		(auto_mode && !ana && mode == ST_LOCK_TO_REFERENCE && enter_data) |=> freq_lock_o && data_pd_en_o)
		else $error("lock conditions did not enter data mode");

	ref_first_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE8
		($past(auto_mode) && $rose(mode == ST_LOCK_TO_DATA)) |-> $past(ref_lock_i && phase_ok))
		else $error("data mode entered without reference lock");

	manual_ref_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE14
		(ctrl.manual_en && ctrl.force_ref && !ctrl.force_data && !ana) [*2] |->
		!freq_lock_o && phase_freq_detector_en_o)
		else $error("force reference left frequency lock high");

	manual_data_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE15
		(ctrl.manual_en && ctrl.force_data && !ana) |=> freq_lock_o && !phase_freq_detector_en_o)
		else $error("force data did not raise frequency lock");

	ana_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE22
		ana |=> !freq_lock_o && !ref_lock_o && mode == ST_LOCK_TO_REFERENCE && !word_valid_o)
		else $error("analog reset did not clear lock state");

	word_strobe_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE18
		last_bit_s ##1 !ser_valid_i |-> word_out_s)
		else $error("word strobe not one cycle after last bit");

	pcs_reset_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE20
		ctrl.dig_rst |=> pcs_rst_o)
		else $error("digital reset not passed to PCS");

	// bus handshake, register write and read data checks
	bus_answer_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		((avs_read_i || avs_write_i) && avs_waitrequest_o) |=> !avs_waitrequest_o)
		else $error("bus request not answered next cycle");

	wait_pulse_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low longer than one cycle");

	ctrl_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(wr_take && avs_byteenable_i[0] && avs_address_i == CTRL_ADDR) |=> ctrl == $past(avs_writedata_i[7:0]))
		else $error("control write did not land");

	rd_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!rd_take |=> $stable(avs_readdata_o))
		else $error("read data changed without a read");

	unmapped_rd_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(rd_take && avs_address_i > WORD_ADDR) |=> avs_readdata_o == 32'h0)
		else $error("unmapped read not zero");

	// loop mode checks
	mode_enables_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE4 RULE5
		!ana |=> (phase_freq_detector_en_o != data_pd_en_o) && (freq_lock_o == data_pd_en_o))
		else $error("detector enables disagree with mode");

	ref_flag_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE4
		!ana |=> ref_lock_o == $past(ref_lock_i))
		else $error("reference lock flag not passed");

	fb_half_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE6
		1'b1 |=> {1'b0, fb_div_o} == ($past(rate) >> 1))
		else $error("feedback divide not half the rate ratio");

	force_both_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE9
		(ctrl.manual_en && ctrl.force_ref && ctrl.force_data && !ana) |=> data_mode_o && !phase_freq_detector_en_o)
		else $error("force data did not win over force reference");

	no_manual_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE10
		(!ctrl.manual_en && !ana && mode == ST_LOCK_TO_REFERENCE && !enter_data) |=> !data_mode_o)
		else $error("force inputs acted without manual option");

	start_ref_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE11
		$fell(ana) |-> mode == ST_LOCK_TO_REFERENCE && !freq_lock_o)
		else $error("loop did not start in reference mode");

	data_entry_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE12
		($rose(data_mode_o) && $past(auto_mode)) |-> $past(sig_det_o && ppm_ok_i))
		else $error("data mode entered without signal and ppm");

	exit_loss_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE13
		(auto_mode && !ana && mode == ST_LOCK_TO_DATA && !sig_det_o && !ppm_ok_i) |=> !freq_lock_o && !data_mode_o)
		else $error("signal and ppm loss did not leave data mode");

	sequence sig_loss_s;
		auto_mode && !ana && mode == ST_LOCK_TO_DATA && !sig_det_o;
	endsequence

	sequence back_ref_s;
		!data_mode_o && phase_freq_detector_en_o;
	endsequence

	loss_enables_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE3
		sig_loss_s |=> back_ref_s)
		else $error("signal loss left data detector on");

	// deserializer, signal detect and PCS reset checks
	// width change mid-word can stretch a word, so no width check here
	sequence first_bit_s;
		ser_valid_i && bit_cnt == 5'h0 && !ana;
	endsequence

	first_lsb_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE17
		first_bit_s |=> asm_word[0] == $past(ser_bit_i))
		else $error("first serial bit not at word bit zero");

	bit_step_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE18
		(ser_valid_i && bit_cnt < last_bit && !ana) |=> bit_cnt == $past(bit_cnt) + 5'h1 && !word_valid_o)
		else $error("bit count did not step per strobe");

	idle_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE18
		(!ser_valid_i && !ana) |=> $stable(bit_cnt) && !word_valid_o)
		else $error("bit count moved without a strobe");

	ana_deser_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE21
		ana |=> bit_cnt == 5'h0 && word_o == '0)
		else $error("analog reset did not clear deserializer");

	ana_detect_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE21
		(ana && !ctrl.force_det) |=> !sig_det_o)
		else $error("analog reset left signal detect high");

	pcs_release_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE20
		!ctrl.dig_rst |=> !pcs_rst_o)
		else $error("PCS reset held without digital reset");

endmodule : cdr_lock_ctrl

// [dv/cdr_far_tx.sv]
// cdr_far_tx: remote serial transmitter model
// assumes one bit strobe per core clock, changed after rising edges
`timescale 1ns/1ps
module cdr_far_tx (
	// clock
	input wire logic clk_i,
	// serial line
	output logic bit_o,
	output logic valid_o
);
	initial begin
		bit_o = 1'b0;
		valid_o = 1'b0;
	end
	// lsb first, strobes back to back
	task automatic send(input logic [19:0] w, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			bit_o <= w[i];
			valid_o <= 1'b1;
		end
		@(posedge clk_i);
		valid_o <= 1'b0;
		// idle line shows the inverse, never a stale bit
		bit_o <= ~w[n-1];
	endtask : send
endmodule : cdr_far_tx

// [dv/tb_top.sv]
// tb_top: bus tasks and directed lock and deserializer tests
// assumes cdr_pkg and a 20 MHz core clock
`timescale 1ns/1ps
module tb_top;
	import cdr_pkg::*;
	logic clk, rst_n, rd, wr, ppm, rl, sb, sv, wt, sd, fl, rlo, dm, pe, de, wv, pr;
	logic [4:0] adr;
	logic [31:0] wd, rdat, q;
	logic [7:0] lvl, c;
	logic [9:0] ph;
	logic [6:0] fb;
	logic [WORD_W-1:0] wo;
	int wl[4] = '{8, 10, 16, 20};
	int num_errors = 0;
	int num_checks = 0;
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	cdr_far_tx far_u (.clk_i(clk), .bit_o(sb), .valid_o(sv));
	cdr_lock_ctrl dut_u (
		.core_clk_i(clk),
		.rst_n_i(rst_n),
		.avs_address_i(adr),
		.avs_read_i(rd),
		.avs_write_i(wr),
		.avs_writedata_i(wd),
		.avs_byteenable_i(4'h1),
		.avs_readdata_o(rdat),
		.avs_waitrequest_o(wt),
		.rx_level_i(lvl),
		.ppm_ok_i(ppm),
		.phase_err_i(ph),
		.ref_lock_i(rl),
		.ser_bit_i(sb),
		.ser_valid_i(sv),
		.sig_det_o(sd),
		.freq_lock_o(fl),
		.ref_lock_o(rlo),
		.data_mode_o(dm),
		.phase_freq_detector_en_o(pe),
		.data_pd_en_o(de),
		.fb_div_o(fb),
		.word_o(wo),
		.word_valid_o(wv),
		.pcs_rst_o(pr)
	);
	task automatic print_verdict;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %0t: saw %h want %h", $time, got, exp);
		end
	endtask : chk
	// request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		wd <= {24'h0, d};
		wr <= w;
		rd <= ~w;
		do begin
			@(posedge clk);
			n++;
		end while (wt !== 1'b0 && n < 16);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 16) begin
			num_errors++;
			print_verdict();
		end
	endtask : bus
	task automatic set(input logic [7:0] l, input logic p, input logic [9:0] f, input logic r);
		@(posedge clk);
		lvl <= l;
		ppm <= p;
		ph <= f;
		rl <= r;
	endtask : set
	// cause, then detect, then mode: two edges
	task automatic st(input logic [3:0] e);
		repeat (2) @(posedge clk);
		#1;
		chk({28'h0, dm, pe, de, fl}, {28'h0, e});
	endtask : st
	task automatic fin(input string s);
		$display("test %s done, errors %0d", s, num_errors);
	endtask : fin
	initial begin
		rst_n = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		adr = 5'h00;
		wd = 32'h0;
		lvl = 8'h00;
		ppm = 1'b0;
		ph = 10'h000;
		rl = 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		bus(0, THR_ADDR, 8'h00);
		chk(q, 32'h40);
		bus(0, RATE_ADDR, 8'h00);
		chk(q, 32'h14);
		chk({25'h0, fb}, 32'h0a);
		bus(0, 5'h14, 8'h00);
		chk(q, 32'h0);
		fin("regs");
		set(8'h41, 0, 10'h000, 0);
		st(4'b0100);
		chk({31'h0, sd}, 1);
		set(8'h40, 0, 10'h000, 0);
		st(4'b0100);
		chk({31'h0, sd}, 0);
		bus(1, CTRL_ADDR, 8'h01);
		st(4'b0100);
		chk({31'h0, sd}, 1);
		bus(1, CTRL_ADDR, 8'h80);
		fin("detect");
		// phase one milli-UI outside, then no reference lock
		set(8'h80, 1, 10'd81, 1);
		st(4'b0100);
		set(8'h80, 1, 10'd80, 0);
		st(4'b0100);
		set(8'h80, 1, 10'd80, 1);
		st(4'b1011);
		bus(0, STAT_ADDR, 8'h00);
		chk(q, 32'h0f);
		chk({31'h0, pr}, 1);
		bus(1, CTRL_ADDR, 8'h00);
		set(8'h00, 0, 10'd80, 1);
		st(4'b0100);
		chk({31'h0, pr}, 0);
		fin("auto");
		set(8'h00, 0, 10'd0, 1);
		for (int i = 0; i < 5; i++) begin
			c = (i < 4) ? {4'h0, i[1:0], 2'b10} : 8'h08;
			bus(1, CTRL_ADDR, c);
			st((i == 2 || i == 3) ? 4'b1011 : 4'b0100);
		end
		bus(1, CTRL_ADDR, 8'h0a);
		set(8'h00, 0, 10'd0, 1);
		st(4'b1011);
		bus(1, CTRL_ADDR, 8'h4a);
		st(4'b0000);
		chk({31'h0, rlo}, 0);
		bus(1, CTRL_ADDR, 8'h80);
		st(4'b0100);
		chk({31'h0, pr}, 1);
		fin("manual");
		// bits above the width must read zero
		for (int i = 0; i < 4; i++) begin
			bus(1, CTRL_ADDR, {2'b00, i[1:0], 4'h0});
			far_u.send(20'hf317c, wl[i]);
			#1;
			chk({31'h0, wv}, 1);
			chk({12'h0, wo}, 32'hf317c & ((1 << wl[i]) - 1));
			@(posedge clk);
			#1;
			chk({31'h0, wv}, 0);
			bus(0, WORD_ADDR, 8'h00);
			chk(q, 32'hf317c & ((1 << wl[i]) - 1));
		end
		fin("deser");
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk({24'h0, pr, fb}, 32'h80);
		@(posedge clk);
		rst_n <= 1'b1;
		bus(0, CTRL_ADDR, 8'h00);
		chk(q, 32'h0);
		chk({25'h0, fb}, 32'h0a);
		fin("reset");
		print_verdict();
	end
endmodule : tb_top
